// [verilog/status_powerdown_update_regs.sv]
// status pin, power-down and update control registers, segment walker
`timescale 1ns/10ps
module status_powerdown_update_regs (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic [11:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    output logic regRdValid,
    input wire logic monitorSig0,
    input wire logic monitorSig1,
    output logic statusPin0,
    output logic statusPin1,
    output logic divSyncHold,
    output logic pdRefLoop,
    output logic pdSynthLoop,
    output logic pdDistribution,
    input wire logic eeLoadReq,
    input wire logic eeSaveReq,
    output logic eeRunValid,
    output logic eeRunSave,
    output logic [15:0] eeRunAddr,
    output logic [7:0] eeRunCount,
    input wire logic eeRunDone,
    output logic eeBusy
);
    ////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers
    logic rstMeta_q;
    logic rstSyncN;
    logic sclkMeta_q;
    logic sclkSync_q;
    logic sclkPrev_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta_q <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSyncN <= rstMeta_q;
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            sclkMeta_q <= 1'b0;
            sclkSync_q <= 1'b0;
            sclkPrev_q <= 1'b0;
        end else begin
            sclkMeta_q <= sclk;
            sclkSync_q <= sclkMeta_q;
            sclkPrev_q <= sclkSync_q;
        end
    end

    wire sclkRise = sclkSync_q & ~sclkPrev_q;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    function automatic logic hitAddr(input logic [11:0] a,
        input logic [11:0] off);
        hitAddr = (a == off);
    endfunction

    wire hitStatus = hitAddr(regAddr, spu_pkg::OFF_STATUS_PIN_SYNC_CONTROL);
    wire hitPower = hitAddr(regAddr, spu_pkg::OFF_POWER_DOWN_CONTROL);
    wire hitUpdate = hitAddr(regAddr, spu_pkg::OFF_UPDATE_ALL_REGISTERS);
    wire hitEeStat = hitAddr(regAddr, spu_pkg::OFF_EEPROM_STATUS);
    wire hitSeg = (regAddr >= spu_pkg::OFF_EEPROM_SEGMENT_FIRST) &&
        (regAddr <= spu_pkg::OFF_EEPROM_SEGMENT_LAST);
    wire [11:0] segOffset = regAddr - spu_pkg::OFF_EEPROM_SEGMENT_FIRST;
    wire [4:0] segIndex = segOffset[4:0];

    ////////////////////////////////////////////////////////////////////////
    // buffer and active registers
    logic [7:0] statusBuf_q;
    logic [7:0] statusAct_q;
    logic [7:0] powerBuf_q;
    logic [7:0] powerAct_q;
    logic updatePend_q;
    logic eeUpdateReq;

    // host writes only reach the buffer copies
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            statusBuf_q <= spu_pkg::STATUS_CTRL_RESET;
            powerBuf_q <= spu_pkg::POWER_DOWN_RESET;
        end else if (regWrite) begin
            if (hitStatus) begin
                statusBuf_q <= regWdata & spu_pkg::STATUS_CTRL_MASK;
            end
            if (hitPower) begin
                powerBuf_q <= regWdata & spu_pkg::POWER_DOWN_MASK;
            end
        end
    end

    wire updateSet = (regWrite && hitUpdate &&
        regWdata[spu_pkg::BIT_UPDATE]) || eeUpdateReq;
    wire updateFire = updatePend_q && sclkRise;

    // a new request in the copy cycle stays pending for the next edge
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            updatePend_q <= 1'b0;
        end else if (updateSet) begin
            updatePend_q <= 1'b1;
        end else if (updateFire) begin
            updatePend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            statusAct_q <= spu_pkg::STATUS_CTRL_RESET;
            powerAct_q <= spu_pkg::POWER_DOWN_RESET;
        end else if (updateFire) begin
            statusAct_q <= statusBuf_q;
            powerAct_q <= powerBuf_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control outputs from the active copies
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            divSyncHold <= 1'b0;
            pdRefLoop <= 1'b1;
            pdSynthLoop <= 1'b1;
            pdDistribution <= 1'b1;
        end else begin
            divSyncHold <= statusAct_q[spu_pkg::BIT_SYNC_DIVIDERS];
            pdRefLoop <= powerAct_q[spu_pkg::BIT_PD_REF_LOOP];
            pdSynthLoop <= powerAct_q[spu_pkg::BIT_PD_SYNTH_LOOP];
            pdDistribution <= powerAct_q[spu_pkg::BIT_PD_DISTRIB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status pins with optional divide-by-4
    logic src0Prev_q;
    logic src1Prev_q;
    logic [1:0] div0_q;
    logic [1:0] div1_q;

    // transfer status replaces the monitor signal on pin 0
    wire src0 = statusAct_q[spu_pkg::BIT_EE_ON_STATUS_PIN_0] ? eeBusy :
        monitorSig0;
    wire src1 = monitorSig1;
    // static monitor codes give a flat pin when divided; host avoids it
    wire div0En = statusAct_q[spu_pkg::BIT_STATUS_PIN_0_DIV];
    wire div1En = statusAct_q[spu_pkg::BIT_STATUS_PIN_1_DIV];

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            src0Prev_q <= 1'b0;
            src1Prev_q <= 1'b0;
            div0_q <= 2'b00;
            div1_q <= 2'b00;
        end else begin
            src0Prev_q <= src0;
            src1Prev_q <= src1;
            if (src0 && !src0Prev_q) begin
                div0_q <= div0_q + 2'b01;
            end
            if (src1 && !src1Prev_q) begin
                div1_q <= div1_q + 2'b01;
            end
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            statusPin0 <= 1'b0;
            statusPin1 <= 1'b0;
        end else begin
            statusPin0 <= div0En ? div0_q[1] : src0;
            statusPin1 <= div1En ? div1_q[1] : src1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer segment memory
    spu_seg_if seg ();

    spu_seg_mem u_seg_mem (
        .clk(clk),
        .rstSyncN(rstSyncN),
        .seg(seg)
    );

    logic [4:0] ptr_q;
    assign seg.wrEn = regWrite && hitSeg;
    assign seg.wrAddr = segIndex;
    assign seg.wrData = regWdata;
    assign seg.busRdAddr = segIndex;
    assign seg.eeRdAddr = ptr_q;

    ////////////////////////////////////////////////////////////////////////
    // segment walker: count byte, address high, address low per run
    spu_pkg::spu_ee_state_e state_q;
    logic [1:0] field_q;
    logic saveDir_q;
    logic [7:0] count_q;
    logic [7:0] addrHi_q;
    logic [7:0] addrLo_q;
    logic runValid_q;
    logic busy_q;
    logic updReq_q;

    wire [7:0] entry = seg.eeRdData;
    wire isEnd = (entry == spu_pkg::OPC_END);
    wire isUpd = (entry == spu_pkg::OPC_UPDATE);
    wire isCount = ~entry[spu_pkg::BIT_OPCODE];
    wire ptrLast = (ptr_q == 5'(spu_pkg::SEG_DEPTH - 1));
    wire [4:0] ptrNext = ptr_q + 5'd1;

    assign eeUpdateReq = updReq_q;

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state_q <= spu_pkg::EE_IDLE;
            ptr_q <= 5'd0;
            field_q <= 2'd0;
            saveDir_q <= 1'b0;
            count_q <= 8'h00;
            addrHi_q <= 8'h00;
            addrLo_q <= 8'h00;
            runValid_q <= 1'b0;
            busy_q <= 1'b0;
            updReq_q <= 1'b0;
        end else begin
            updReq_q <= 1'b0;
            case (state_q)
                spu_pkg::EE_IDLE: begin
                    if (eeLoadReq || eeSaveReq) begin
                        saveDir_q <= eeSaveReq;
                        ptr_q <= 5'd0;
                        field_q <= 2'd0;
                        busy_q <= 1'b1;
                        state_q <= spu_pkg::EE_FETCH;
                    end
                end
                spu_pkg::EE_FETCH: begin
                    state_q <= spu_pkg::EE_DECODE;
                end
                spu_pkg::EE_DECODE: begin
                    state_q <= spu_pkg::EE_FETCH;
                    ptr_q <= ptrNext;
                    case (field_q)
                        2'd0: begin
                            if (isEnd) begin
                                state_q <= spu_pkg::EE_IDLE;
                                busy_q <= 1'b0;
                            end else if (isUpd) begin
                                updReq_q <= 1'b1;
                            end else if (isCount) begin
                                count_q <= entry;
                                field_q <= 2'd1;
                            end
                        end
                        2'd1: begin
                            addrHi_q <= entry;
                            field_q <= 2'd2;
                        end
                        default: begin
                            addrLo_q <= entry;
                            field_q <= 2'd0;
                            runValid_q <= 1'b1;
                            state_q <= spu_pkg::EE_RUN;
                        end
                    endcase
                    // a segment with no end code stops at its last byte
                    if (ptrLast && !(field_q == 2'd2)) begin
                        state_q <= spu_pkg::EE_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                spu_pkg::EE_RUN: begin
                    if (eeRunDone) begin
                        runValid_q <= 1'b0;
                        // a run that used the last byte ends the walk
                        if (ptr_q == 5'(spu_pkg::SEG_DEPTH)) begin
                            state_q <= spu_pkg::EE_IDLE;
                            busy_q <= 1'b0;
                        end else begin
                            state_q <= spu_pkg::EE_FETCH;
                        end
                    end
                end
                default: begin
                    state_q <= spu_pkg::EE_IDLE;
                    busy_q <= 1'b0;
                    runValid_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            eeRunValid <= 1'b0;
            eeRunSave <= 1'b0;
            eeRunAddr <= 16'h0000;
            eeRunCount <= 8'h00;
            eeBusy <= 1'b0;
        end else begin
            eeRunValid <= runValid_q && !eeRunDone;
            eeRunSave <= saveDir_q;
            eeRunAddr <= {addrHi_q, addrLo_q};
            eeRunCount <= count_q + 8'h01;
            eeBusy <= busy_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path: two cycles so segment data can leave its register
    logic rdPend_q;
    logic rdSeg_q;
    logic [7:0] rdLocal_q;
    logic [7:0] localData;

    assign localData = hitStatus ? statusBuf_q :
        hitPower ? powerBuf_q :
        hitUpdate ? {7'h00, updatePend_q} :
        hitEeStat ? {7'h00, eeBusy} : 8'h00;

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rdPend_q <= 1'b0;
            rdSeg_q <= 1'b0;
            rdLocal_q <= 8'h00;
            regRdata <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            rdPend_q <= regRead;
            rdSeg_q <= hitSeg;
            rdLocal_q <= localData;
            regRdValid <= rdPend_q;
            if (rdPend_q) begin
                regRdata <= rdSeg_q ? seg.busRdData : rdLocal_q;
            end
        end
    end
endmodule // status_powerdown_update_regs

// [verilog/spu_pkg.sv]
// package: offsets, field positions, reset values and states of the block
package spu_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_STATUS_PIN_SYNC_CONTROL = 12'h0232;
    localparam logic [11:0] OFF_POWER_DOWN_CONTROL = 12'h0233;
    localparam logic [11:0] OFF_UPDATE_ALL_REGISTERS = 12'h0234;
    localparam logic [11:0] OFF_EEPROM_SEGMENT_FIRST = 12'h0A00;
    localparam logic [11:0] OFF_EEPROM_SEGMENT_LAST = 12'h0A16;
    localparam logic [11:0] OFF_EEPROM_STATUS = 12'h0B00;
    localparam int SEG_DEPTH = 23;
    localparam int SEG_AW = 5;
    // status_pin_sync_control fields
    localparam int BIT_EE_ON_STATUS_PIN_0 = 4;
    localparam int BIT_STATUS_PIN_1_DIV = 3;
    localparam int BIT_STATUS_PIN_0_DIV = 2;
    localparam int BIT_SYNC_DIVIDERS = 0;
    localparam logic [7:0] STATUS_CTRL_MASK = 8'h1D;
    localparam logic [7:0] STATUS_CTRL_RESET = 8'h00;
    // power_down_control fields
    localparam int BIT_PD_REF_LOOP = 2;
    localparam int BIT_PD_SYNTH_LOOP = 1;
    localparam int BIT_PD_DISTRIB = 0;
    localparam logic [7:0] POWER_DOWN_MASK = 8'h07;
    localparam logic [7:0] POWER_DOWN_RESET = 8'h07;
    localparam int BIT_UPDATE = 0;
    localparam int BIT_EE_BUSY = 0;
    // buffer segment entry codes
    localparam logic [7:0] OPC_UPDATE = 8'h80;
    localparam logic [7:0] OPC_END = 8'hFF;
    localparam int BIT_OPCODE = 7;
    // default segment: six 128-byte runs over 0x0000 to 0x02FF, update, end
    localparam logic [7:0] SEG_RESET [SEG_DEPTH] = '{
        8'h7F, 8'h00, 8'h00,
        8'h7F, 8'h00, 8'h80,
        8'h7F, 8'h01, 8'h00,
        8'h7F, 8'h01, 8'h80,
        8'h7F, 8'h02, 8'h00,
        8'h7F, 8'h02, 8'h80,
        8'h80, 8'hFF, 8'hFF, 8'hFF, 8'hFF
    };
    typedef enum logic [2:0] {
        EE_IDLE, EE_FETCH, EE_DECODE, EE_RUN
    } spu_ee_state_e;
endpackage

// [verilog/spu_seg_if.sv]
// interface: ports of the buffer segment memory
`timescale 1ns/10ps
interface spu_seg_if;
    logic wrEn;
    logic [4:0] wrAddr;
    logic [7:0] wrData;
    logic [4:0] busRdAddr;
    logic [7:0] busRdData;
    logic [4:0] eeRdAddr;
    logic [7:0] eeRdData;
    modport ctrl (output wrEn, wrAddr, wrData, busRdAddr, eeRdAddr,
        input busRdData, eeRdData);
    modport mem (input wrEn, wrAddr, wrData, busRdAddr, eeRdAddr,
        output busRdData, eeRdData);
endinterface

// [verilog/spu_seg_mem.sv]
// buffer segment memory: 23 bytes, two registered read ports
`timescale 1ns/10ps
module spu_seg_mem (
    input wire logic clk,
    input wire logic rstSyncN,
    spu_seg_if.mem seg
);
    logic [7:0] mem_q [spu_pkg::SEG_DEPTH];

    // flops rather than a ram block so the reset image is loaded by reset
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            for (int i = 0; i < spu_pkg::SEG_DEPTH; i++) begin
                mem_q[i] <= spu_pkg::SEG_RESET[i];
            end
        end else if (seg.wrEn) begin
            mem_q[seg.wrAddr] <= seg.wrData;
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            seg.busRdData <= 8'h00;
            seg.eeRdData <= 8'h00;
        end else begin
            seg.busRdData <= mem_q[seg.busRdAddr];
            seg.eeRdData <= mem_q[seg.eeRdAddr];
        end
    end
endmodule // spu_seg_mem

// [test/spu_regs_monitor.sv]
// checker: timing relations at the ports of the control register block
`timescale 1ns/10ps
module spu_regs_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic regRead,
    input wire logic regRdValid,
    input wire logic pdDistribution,
    input wire logic divSyncHold,
    input wire logic eeLoadReq,
    input wire logic eeSaveReq,
    input wire logic eeRunValid,
    input wire logic [15:0] eeRunAddr,
    input wire logic [7:0] eeRunCount,
    input wire logic eeRunDone,
    input wire logic eeBusy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // recent serial clock levels; copies may only follow a rise
    logic [6:0] sclkHist_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclkHist_q <= 7'h00;
        end else begin
            sclkHist_q <= {sclkHist_q[5:0], sclk};
        end
    end
    ////////////////////////////////////////////////////////////////////
    AST_PD_ON_SCLK: assert property (
        $changed(pdDistribution) |-> (|sclkHist_q))
        else $error("power-down output moved without serial clock");
    AST_SYNC_ON_SCLK: assert property (
        $changed(divSyncHold) |-> (|sclkHist_q))
        else $error("sync hold moved without serial clock");
    AST_RD_LAT: assert property (
        regRead |-> ##2 regRdValid)
        else $error("read answer late or missing");
    AST_RDV_CAUSE: assert property (
        regRdValid |-> $past(regRead, 2))
        else $error("read answer without request");
    AST_RUN_HOLD: assert property (
        eeRunValid && !eeRunDone |=> eeRunValid)
        else $error("run offer withdrawn early");
    AST_RUN_STABLE: assert property (
        eeRunValid && !eeRunDone |=> $stable(eeRunAddr) && $stable(eeRunCount))
        else $error("run descriptor changed while offered");
    AST_RUN_BUSY: assert property (
        eeRunValid |-> eeBusy)
        else $error("run offered while not busy");
    AST_BUSY_START: assert property (
        $rose(eeBusy) |-> $past(eeLoadReq, 2) || $past(eeSaveReq, 2))
        else $error("busy rose without start request");
    COV_RUN: cover property (eeRunValid && eeRunDone);
endmodule // spu_regs_monitor

bind status_powerdown_update_regs spu_regs_monitor u_mon (
    .clk(clk), .rstn(rstn), .sclk(sclk), .regRead(regRead),
    .regRdValid(regRdValid), .pdDistribution(pdDistribution),
    .divSyncHold(divSyncHold), .eeLoadReq(eeLoadReq), .eeSaveReq(eeSaveReq),
    .eeRunValid(eeRunValid), .eeRunAddr(eeRunAddr), .eeRunCount(eeRunCount),
    .eeRunDone(eeRunDone), .eeBusy(eeBusy));

// [test/spu_ee_partner.sv]
// model of the storage side of the run port: answers each offered run
`timescale 1ns/10ps
module spu_ee_partner (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] latency,
    input wire logic eeRunValid,
    input wire logic eeRunSave,
    input wire logic [15:0] eeRunAddr,
    input wire logic [7:0] eeRunCount,
    output logic eeRunDone
);
    int waitCnt;
    int nRuns;
    logic doneSeen;
    logic lastSave;
    logic [15:0] lastAddr;
    logic [7:0] lastCount;
    // done is pulsed once per offer, only while the offer stands
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            eeRunDone <= 1'b0;
            waitCnt <= 0;
            nRuns <= 0;
            doneSeen <= 1'b0;
        end else begin
            eeRunDone <= 1'b0;
            if (!eeRunValid) begin
                doneSeen <= 1'b0;
                waitCnt <= 0;
            end else if (!doneSeen && waitCnt >= int'(latency)) begin
                eeRunDone <= 1'b1;
                doneSeen <= 1'b1;
                nRuns <= nRuns + 1;
                lastAddr <= eeRunAddr;
                lastCount <= eeRunCount;
                lastSave <= eeRunSave;
            end else if (!doneSeen) begin
                waitCnt <= waitCnt + 1;
            end
        end
    end
endmodule // spu_ee_partner

// [test/tb_top.sv]
// testbench: register, update, status pin and segment walker scenarios
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sclk = 1'b0;
    logic [11:0] regAddr = 12'h000;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic monitorSig0 = 1'b0;
    logic monitorSig1 = 1'b0;
    logic eeLoadReq = 1'b0;
    logic eeSaveReq = 1'b0;
    logic [3:0] lat = 4'h0;
    logic [7:0] regRdata;
    logic regRdValid, statusPin0, statusPin1, divSyncHold;
    logic pdRefLoop, pdSynthLoop, pdDistribution;
    logic eeRunValid, eeRunSave, eeRunDone, eeBusy;
    logic [15:0] eeRunAddr;
    logic [7:0] eeRunCount;
    int miscompares = 0;
    int n_compared = 0;
    int base;
    status_powerdown_update_regs u_dut (.clk(clk), .rstn(rstn), .sclk(sclk),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .regRdValid(regRdValid),
        .monitorSig0(monitorSig0), .monitorSig1(monitorSig1),
        .statusPin0(statusPin0), .statusPin1(statusPin1),
        .divSyncHold(divSyncHold), .pdRefLoop(pdRefLoop),
        .pdSynthLoop(pdSynthLoop), .pdDistribution(pdDistribution),
        .eeLoadReq(eeLoadReq), .eeSaveReq(eeSaveReq), .eeRunValid(eeRunValid),
        .eeRunSave(eeRunSave), .eeRunAddr(eeRunAddr), .eeRunCount(eeRunCount),
        .eeRunDone(eeRunDone), .eeBusy(eeBusy));
    spu_ee_partner u_ee (.clk(clk), .rstn(rstn), .latency(lat),
        .eeRunValid(eeRunValid), .eeRunSave(eeRunSave), .eeRunAddr(eeRunAddr),
        .eeRunCount(eeRunCount), .eeRunDone(eeRunDone));
    initial begin
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        int k;
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        for (k = 0; k < 4 && regRdValid !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk({7'h00, regRdValid, regRdata}, {8'h01, exp});
    endtask
    // serial clock stands low between updates, one clean pulse each
    task automatic upd(input logic [7:0] ctl);
        wr(12'h0232, ctl);
        wr(12'h0234, 8'h01);
        @(posedge clk);
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
        sclk <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic pulses(input int n, input int e0, input int e1);
        int k, r0, r1;
        logic p0, p1;
        r0 = 0;
        r1 = 0;
        for (k = 0; k < 4 * n + 8; k++) begin
            p0 = statusPin0;
            p1 = statusPin1;
            @(posedge clk);
            monitorSig0 <= (k < 4 * n) ? k[1] : 1'b0;
            monitorSig1 <= (k < 4 * n) ? k[1] : 1'b0;
            #1;
            r0 += int'(statusPin0 === 1'b1 && p0 === 1'b0);
            r1 += int'(statusPin1 === 1'b1 && p1 === 1'b0);
        end
        chk(16'(r0), 16'(e0));
        chk(16'(r1), 16'(e1));
    endtask
    task automatic ee(input logic save, input int checkBusy);
        int k;
        base = u_ee.nRuns;
        @(posedge clk);
        eeSaveReq <= save;
        eeLoadReq <= !save;
        @(posedge clk);
        eeSaveReq <= 1'b0;
        eeLoadReq <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        if (checkBusy != 0) begin
            chk(eeBusy, 1'b1);
            chk(statusPin0, 1'b1);
            rd(spu_pkg::OFF_EEPROM_STATUS, 8'h01);
        end
        for (k = 0; k < 9000 && eeBusy !== 1'b0; k++) @(posedge clk);
        repeat (3) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({pdRefLoop, pdSynthLoop, pdDistribution}, 3'h7);
        chk(divSyncHold, 1'b0);
        rd(12'h0232, 8'h00);
        rd(12'h0233, 8'h07);
        rd(12'h0234, 8'h00);
        rd(12'h0235, 8'h00);
        rd(spu_pkg::OFF_EEPROM_STATUS, 8'h00);
        for (int i = 0; i < spu_pkg::SEG_DEPTH; i++) begin
            rd(spu_pkg::OFF_EEPROM_SEGMENT_FIRST + 12'(i),
                spu_pkg::SEG_RESET[i]);
        end
        // buffered writes must not reach the outputs yet
        wr(12'h0233, 8'h00);
        wr(12'h0232, 8'h01);
        repeat (10) @(posedge clk);
        #1;
        chk({pdRefLoop, pdSynthLoop, pdDistribution}, 3'h7);
        chk(divSyncHold, 1'b0);
        rd(12'h0233, 8'h00);
        wr(12'h0234, 8'h01);
        rd(12'h0234, 8'h01);
        upd(8'h01);
        chk({pdRefLoop, pdSynthLoop, pdDistribution}, 3'h0);
        chk(divSyncHold, 1'b1);
        rd(12'h0234, 8'h00);
        wr(12'h0233, 8'h05);
        upd(8'h00);
        chk({pdRefLoop, pdSynthLoop, pdDistribution}, 3'h5);
        chk(divSyncHold, 1'b0);
        // dividers on only while the monitors carry dynamic signals
        upd(8'h0C);
        pulses(16, 4, 4);
        upd(8'h00);
        pulses(8, 8, 8);
        upd(8'h10);
        lat <= 4'h7;
        ee(1'b0, 1);
        chk(statusPin0, 1'b0);
        rd(spu_pkg::OFF_EEPROM_STATUS, 8'h00);
        chk(16'(u_ee.nRuns - base), 16'h0006);
        chk(u_ee.lastAddr, 16'h0280);
        chk(u_ee.lastCount, 8'h80);
        rd(12'h0234, 8'h01);
        upd(8'h00);
        lat <= 4'h0;
        wr(12'h0A00, 8'h01);
        wr(12'h0A01, 8'h12);
        wr(12'h0A02, 8'h34);
        wr(12'h0A03, spu_pkg::OPC_UPDATE);
        wr(12'h0A04, spu_pkg::OPC_END);
        ee(1'b1, 0);
        chk(16'(u_ee.nRuns - base), 16'h0001);
        chk(u_ee.lastAddr, 16'h1234);
        chk({7'h00, u_ee.lastSave, u_ee.lastCount}, 16'h0102);
        rd(12'h0234, 8'h01);
        upd(8'h00);
        wr(12'h0A00, spu_pkg::OPC_END);
        ee(1'b0, 0);
        chk(16'(u_ee.nRuns - base), 16'h0000);
        rd(12'h0234, 8'h00);
        wrap_up();
    end
endmodule // tb_top
